// ---- common/dlx_dec_if.sv ----
`timescale 1ns/1ps
// Decoded instruction passed from decoder to execute logic
interface dlx_dec_if;
  dlx_pkg::dlx_op_type op;
  logic [7:0] literal;
  logic [6:0] index;
  logic dest_file;
  modport dec (output op, literal, index, dest_file);
  modport exe (input op, literal, index, dest_file);
endinterface

// ---- common/dlx_pkg.sv ----
package dlx_pkg;
  typedef enum logic [1:0] {
    DLX_OP_NONE = 2'h0,
    DLX_OP_DIR = 2'h1,
    DLX_OP_XORL = 2'h3,
    DLX_OP_XORF = 2'h2
  } dlx_op_type;
endpackage

// ---- common/dlx_regs.svh ----
`ifndef DLX_REGS_SVH
`define DLX_REGS_SVH
// Opcode fields of the 14-bit instruction word
`define DLX_OP_DIR_MASK 14'h3FF8
`define DLX_OP_DIR_VAL 14'h0060
`define DLX_OP_XORL_MASK 14'h3F00
`define DLX_OP_XORL_VAL 14'h3A00
`define DLX_OP_XORF_MASK 14'h3F00
`define DLX_OP_XORF_VAL 14'h0600
`define DLX_DEST_BIT 7
`define DLX_DIR_FIRST 3'h5
`define DLX_DIR_LAST 3'h7
`define DLX_DIR_RESET 8'hFF
`define DLX_ACC_RESET 8'h00
`define DLX_FILE_WORDS 128
`endif

// ---- hdl/dlx_core.sv ----
`timescale 1ns/1ps
`include "dlx_regs.svh"
// Behaviour
// - direction_load copies accumulator into direction register 5-7, flags untouched.
// - direction registers are also plainly writable by address and read on their own outputs.
// - xor_literal_acc forms accumulator XOR 8-bit literal, any value 0-255.
// - xor_literal_acc writes accumulator and changes only the zero flag.
// - xor_acc_register XORs accumulator with file register 0 to 127.
// - destination bit 0 writes accumulator, 1 writes back the file register.
module dlx_core #(
  parameter int FILE_WORDS = `DLX_FILE_WORDS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [13:0] instr,
  input wire logic instr_valid,
  input wire logic dir_wr_en,
  input wire logic [1:0] dir_wr_sel,
  input wire logic [7:0] dir_wr_data,
  input wire logic file_wr_en,
  input wire logic [6:0] file_wr_addr,
  input wire logic [7:0] file_wr_data,
  input wire logic [6:0] file_rd_addr,
  output logic [7:0] acc_r,
  output logic zero_r,
  output logic [7:0] dir5_r,
  output logic [7:0] dir6_r,
  output logic [7:0] dir7_r,
  output logic [7:0] file_rd_data_r,
  output logic done_r
);
  dlx_dec_if dif ();
  logic [7:0] file_mem [FILE_WORDS];
  logic [7:0] operand;
  logic [7:0] xor_nxt;

  dlx_decoder u_dec (
    .instr(instr),
    .instr_valid(instr_valid),
    .dec(dif)
  );

  // Second operand chosen by instruction form
  assign operand = (dif.op == dlx_pkg::DLX_OP_XORL) ? dif.literal : file_mem[dif.index];
  assign xor_nxt = acc_r ^ operand;

  // Accumulator update, one cycle per instruction
  always_ff @(posedge clk) begin
    if (reset) begin
      acc_r <= `DLX_ACC_RESET;
    end else if (dif.op == dlx_pkg::DLX_OP_XORL) begin
      acc_r <= xor_nxt;
    end else if (dif.op == dlx_pkg::DLX_OP_XORF && !dif.dest_file) begin
      acc_r <= xor_nxt;
    end
  end

  // Zero flag moves only on XOR forms; direction load leaves it alone
  always_ff @(posedge clk) begin
    if (reset) begin
      zero_r <= 1'b0;
    end else if (dif.op == dlx_pkg::DLX_OP_XORL || dif.op == dlx_pkg::DLX_OP_XORF) begin
      zero_r <= (xor_nxt == 8'h00);
    end
  end

  // File register array; the instruction write wins over a same-cycle side write
  always_ff @(posedge clk) begin
    if (dif.op == dlx_pkg::DLX_OP_XORF && dif.dest_file) begin
      file_mem[dif.index] <= xor_nxt;
    end else if (file_wr_en) begin
      file_mem[file_wr_addr] <= file_wr_data;
    end
  end

  // Registered read port of the file
  always_ff @(posedge clk) begin
    if (reset) begin
      file_rd_data_r <= 8'h00;
    end else begin
      file_rd_data_r <= file_mem[file_rd_addr];
    end
  end

  // Direction registers: instruction load has priority over a direct write
  always_ff @(posedge clk) begin
    if (reset) begin
      dir5_r <= `DLX_DIR_RESET;
      dir6_r <= `DLX_DIR_RESET;
      dir7_r <= `DLX_DIR_RESET;
    end else if (dif.op == dlx_pkg::DLX_OP_DIR) begin
      unique case (instr[1:0])
        2'h1: dir5_r <= acc_r;
        2'h2: dir6_r <= acc_r;
        2'h3: dir7_r <= acc_r;
        default: ;
      endcase
    end else if (dir_wr_en) begin
      // Direct access path so software need not use the load instruction
      unique case (dir_wr_sel)
        2'h1: dir5_r <= dir_wr_data;
        2'h2: dir6_r <= dir_wr_data;
        2'h3: dir7_r <= dir_wr_data;
        default: ;
      endcase
    end
  end

  // Completion strobe one cycle after an accepted instruction
  always_ff @(posedge clk) begin
    if (reset) begin
      done_r <= 1'b0;
    end else begin
      done_r <= (dif.op != dlx_pkg::DLX_OP_NONE);
    end
  end

  property p_xorl_acc;
    logic [7:0] v;
    @(posedge clk) disable iff (reset)
    (dif.op == dlx_pkg::DLX_OP_XORL, v = xor_nxt) |=> (acc_r == v && zero_r == (v == 8'h00));
  endproperty
  a_xorl_acc: assert property (p_xorl_acc) else $error("literal xor result wrong");

  property p_dir_keeps_flag;
    @(posedge clk) disable iff (reset)
    (dif.op == dlx_pkg::DLX_OP_DIR) |=> ($stable(zero_r) && $stable(acc_r));
  endproperty
  a_dir_keeps_flag: assert property (p_dir_keeps_flag)
    else $error("direction load moved flags");

  property p_dir7_load;
    @(posedge clk) disable iff (reset)
    (dif.op == dlx_pkg::DLX_OP_DIR && instr[1:0] == 2'h3) |=> (dir7_r == $past(acc_r));
  endproperty
  a_dir7_load: assert property (p_dir7_load) else $error("direction 7 not loaded");

  property p_dir_direct;
    @(posedge clk) disable iff (reset)
    (dif.op == dlx_pkg::DLX_OP_NONE && dir_wr_en && dir_wr_sel == 2'h1)
      |=> (dir5_r == $past(dir_wr_data));
  endproperty
  a_dir_direct: assert property (p_dir_direct)
    else $error("direct direction write lost");

  property p_xorf_acc;
    logic [7:0] v;
    @(posedge clk) disable iff (reset)
    (dif.op == dlx_pkg::DLX_OP_XORF && !dif.dest_file, v = acc_r ^ file_mem[dif.index])
      |=> (acc_r == v);
  endproperty
  a_xorf_acc: assert property (p_xorf_acc) else $error("register xor to acc wrong");

  property p_xorf_file;
    logic [6:0] a;
    logic [7:0] v;
    @(posedge clk) disable iff (reset)
    (dif.op == dlx_pkg::DLX_OP_XORF && dif.dest_file, a = dif.index, v = xor_nxt)
      |=> (file_mem[a] == v && $stable(acc_r));
  endproperty
  a_xorf_file: assert property (p_xorf_file)
    else $error("register xor write-back wrong");

  property p_xorf_zero;
    @(posedge clk) disable iff (reset)
    (dif.op == dlx_pkg::DLX_OP_XORF) |=> (zero_r == ($past(xor_nxt) == 8'h00));
  endproperty
  a_xorf_zero: assert property (p_xorf_zero) else $error("zero flag wrong");

  property p_done;
    @(posedge clk) disable iff (reset)
    (instr_valid && dif.op != dlx_pkg::DLX_OP_NONE) |=> done_r ##1
      (done_r == $past(instr_valid && dif.op != dlx_pkg::DLX_OP_NONE));
  endproperty
  a_done: assert property (p_done) else $error("completion not in one cycle");

  // Each selector must land in its own register, even against a direct write
  property p_dir5_load;
    @(posedge clk) disable iff (reset)
    (dif.op == dlx_pkg::DLX_OP_DIR && instr[1:0] == 2'h1) |=> (dir5_r == $past(acc_r));
  endproperty
  a_dir5_load: assert property (p_dir5_load)
    else $error("direction 5 not loaded");

  property p_dir6_load;
    @(posedge clk) disable iff (reset)
    (dif.op == dlx_pkg::DLX_OP_DIR && instr[1:0] == 2'h2) |=> (dir6_r == $past(acc_r));
  endproperty
  a_dir6_load: assert property (p_dir6_load)
    else $error("direction 6 not loaded");

  // An idle or refused word must leave accumulator and flag alone
  property p_idle_holds;
    @(posedge clk) disable iff (reset)
    (dif.op == dlx_pkg::DLX_OP_NONE) |=> ($stable(acc_r) && $stable(zero_r) && !done_r);
  endproperty
  a_idle_holds: assert property (p_idle_holds)
    else $error("idle cycle moved state");

  // Literal form touches only accumulator and zero flag
  property p_xorl_keeps_dirs;
    @(posedge clk) disable iff (reset)
    (dif.op == dlx_pkg::DLX_OP_XORL && !dir_wr_en)
      |=> ($stable(dir5_r) && $stable(dir6_r) && $stable(dir7_r));
  endproperty
  a_xorl_keeps_dirs: assert property (p_xorl_keeps_dirs)
    else $error("literal xor moved a direction register");

  // Accepted word followed by the completion pulse on the very next edge
  sequence s_word_taken;
    dif.op != dlx_pkg::DLX_OP_NONE;
  endsequence

  sequence s_done_seen;
    done_r;
  endsequence

  property p_done_next;
    @(posedge clk) disable iff (reset)
    s_word_taken |=> s_done_seen;
  endproperty
  a_done_next: assert property (p_done_next)
    else $error("completion pulse missing");
endmodule

// ---- hdl/dlx_decoder.sv ----
`timescale 1ns/1ps
`include "dlx_regs.svh"
// Pure combinational opcode decode
module dlx_decoder (
  input wire logic [13:0] instr,
  input wire logic instr_valid,
  dlx_dec_if.dec dec
);
  // Match each opcode pattern; direction load only for selectors 5..7
  always_comb begin
    dec.op = dlx_pkg::DLX_OP_NONE;
    dec.literal = instr[7:0];
    dec.index = instr[6:0];
    dec.dest_file = instr[`DLX_DEST_BIT];
    if (instr_valid) begin
      if ((instr & `DLX_OP_DIR_MASK) == `DLX_OP_DIR_VAL &&
          instr[2:0] >= `DLX_DIR_FIRST) begin
        dec.op = dlx_pkg::DLX_OP_DIR;
      end else if ((instr & `DLX_OP_XORL_MASK) == `DLX_OP_XORL_VAL) begin
        dec.op = dlx_pkg::DLX_OP_XORL;
      end else if ((instr & `DLX_OP_XORF_MASK) == `DLX_OP_XORF_VAL) begin
        dec.op = dlx_pkg::DLX_OP_XORF;
      end
    end
  end
endmodule

// ---- verification/dlx_core_tb_top.sv ----
`timescale 1ns/1ps
module dlx_core_tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [13:0] instr = 14'h0000;
  logic instr_valid = 1'b0;
  logic dir_wr_en = 1'b0;
  logic [1:0] dir_wr_sel = 2'h0;
  logic [7:0] dir_wr_data = 8'h00;
  logic file_wr_en = 1'b0;
  logic [6:0] file_wr_addr = 7'h00;
  logic [7:0] file_wr_data = 8'h00;
  logic [6:0] file_rd_addr = 7'h7F;
  logic [7:0] acc_r, dir5_r, dir6_r, dir7_r, file_rd_data_r;
  logic zero_r, done_r;
  int fails = 0;
  int cmp_count = 0;

  dlx_core uut (.clk(clk), .reset(reset), .instr(instr), .instr_valid(instr_valid),
    .dir_wr_en(dir_wr_en), .dir_wr_sel(dir_wr_sel), .dir_wr_data(dir_wr_data),
    .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data),
    .file_rd_addr(file_rd_addr), .acc_r(acc_r), .zero_r(zero_r), .dir5_r(dir5_r),
    .dir6_r(dir6_r), .dir7_r(dir7_r), .file_rd_data_r(file_rd_data_r), .done_r(done_r));

  // Free-running 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Valid is left high so instructions can follow back to back
  task automatic run(input logic [13:0] word);
    instr = word;
    instr_valid = 1'b1;
    @(posedge clk);
    #1;
  endtask

  // One idle edge; the only place valid drops
  task automatic stop();
    instr_valid = 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic t_xorl();
    run(14'h3AB5);
    check("acc", acc_r, 8'hB5);
    run(14'h3AAF);
    check("acc", acc_r, 8'h1A);
    check("zero", {7'h00, zero_r}, 8'h00);
    check("done", {7'h00, done_r}, 8'h01);
    run(14'h3A1A);
    check("zero", {7'h00, zero_r}, 8'h01);
    run(14'h3AFF);
    check("acc", acc_r, 8'hFF);
    stop();
    check("done", {7'h00, done_r}, 8'h00);
  endtask

  // Zero flag is set first so an unwanted flag change on the load shows
  task automatic t_dir();
    run(14'h3AFF);
    for (int i = 5; i <= 7; i++) begin
      run(14'h0060 | 14'(i));
      check("dir5", dir5_r, 8'h00);
      check("dir6", dir6_r, (i >= 6) ? 8'h00 : 8'hFF);
      check("dir7", dir7_r, (i >= 7) ? 8'h00 : 8'hFF);
    end
    run(14'h0064);
    check("done", {7'h00, done_r}, 8'h00);
    stop();
    check("dir5", dir5_r, 8'h00);
    check("dir6", dir6_r, 8'h00);
    check("dir7", dir7_r, 8'h00);
    check("zero", {7'h00, zero_r}, 8'h01);
  endtask

  task automatic t_direct();
    dir_wr_en = 1'b1;
    dir_wr_sel = 2'h2;
    dir_wr_data = 8'h3C;
    file_wr_en = 1'b1;
    file_wr_data = 8'hAF;
    file_wr_addr = 7'h7F;
    @(posedge clk);
    #1;
    dir_wr_sel = 2'h1;
    dir_wr_data = 8'hC3;
    file_wr_en = 1'b0;
    @(posedge clk);
    #1;
    check("dir5", dir5_r, 8'hC3);
    // Load of selector 5 must beat the direct write in the same cycle
    dir_wr_data = 8'h55;
    run(14'h0065);
    check("dir5", dir5_r, 8'h00);
    dir_wr_en = 1'b0;
    stop();
    check("dir6", dir6_r, 8'h3C);
    check("dir7", dir7_r, 8'h00);
    check("file", file_rd_data_r, 8'hAF);
  endtask

  // Top index exercises the full 7-bit field
  task automatic t_xorf();
    run(14'h3AB5);
    run(14'h06FF);
    check("zero", {7'h00, zero_r}, 8'h00);
    check("done", {7'h00, done_r}, 8'h01);
    stop();
    check("file", file_rd_data_r, 8'h1A);
    check("acc", acc_r, 8'hB5);
    run(14'h067F);
    check("acc", acc_r, 8'hAF);
    run(14'h3AB5);
    run(14'h067F);
    check("acc", acc_r, 8'h00);
    check("zero", {7'h00, zero_r}, 8'h01);
    stop();
    check("file", file_rd_data_r, 8'h1A);
  endtask

  task automatic finish_test();
    $display("Compared %0d mismatched %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Whole run is under 60 cycles
  initial begin
    #2000;
    fails++;
    finish_test();
  end

  initial begin
    repeat (5) @(posedge clk);
    #1;
    reset = 1'b0;
    check("acc", acc_r, 8'h00);
    check("dir7", dir7_r, 8'hFF);
    t_xorl();
    t_dir();
    t_direct();
    t_xorf();
    finish_test();
  end
endmodule
